// ==== verilog/spi_register_access_slave.sv ====
// serial slave port giving an outside master access to the 14-bit register space
//
// What this block does
// - Pure slave; master starts every transfer and supplies the serial clock.
// - Serial output is driven only while shifting read data back.
// - Bits 3 or 4 set at 3FFFh select lsb first, else msb first.
// - After reset bit order is msb first.
// - Phase 0: sample on leading edge, launch on trailing edge.
// - Phase 1: sample on trailing edge, launch on next leading edge.
// - Serial clock activity while deselected does no harm.
// - First 16 clocks carry direction, 14-bit address, burst flag.
// - Direction 1 reads, 0 writes; burst 1 multi-byte, 0 single byte.
// - In lsb-first mode the 14 address bits arrive reversed.
// - Single read: device shifts out the addressed byte, master deselects.
// - Burst write stores each byte while the queue has room, increments address, keeps accepting.
// - Burst address wraps from 3FFFh to 0000h.
// - Burst read increments address and prefetches next byte without gaps.
// - Chip select rising resets the port, waits for a new transaction.
// - A write byte cut off before its last sample is never stored.
`include "spi_register_access_consts.svh"
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// small fifo; DEPTH must be a power of two
// ----------------------------------------------------------------------------
module word_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  wire push;
  wire pop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wrPtr] <= inData;
  end
endmodule : word_fifo

// ----------------------------------------------------------------------------
// serial port
// ----------------------------------------------------------------------------
module spi_register_access_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdoOut,
  output logic sdoOe,
  input wire logic clockPhaseSelectPin,
  // register write port
  output logic wrValid,
  output spi_register_access_pkg::wr_word_s wrWord,
  input wire logic wrReady,
  // register read port, data expected the cycle after the request
  output logic rdReq,
  output logic [`SRA_ADDR_W-1:0] rdAddr,
  input wire logic [`SRA_DATA_W-1:0] rdData,
  // status
  output logic bitOrderLsb,
  output logic wrOverrun,
  output logic bufReady
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [`SRA_ADDR_W-1:0] rev14(input logic [`SRA_ADDR_W-1:0] v);
    logic [`SRA_ADDR_W-1:0] r;
    r = '0;
    for (int i = 0; i < `SRA_ADDR_W; i++) r[i] = v[`SRA_ADDR_W-1-i];
    return r;
  endfunction : rev14

  function automatic logic [`SRA_DATA_W-1:0] rev8(input logic [`SRA_DATA_W-1:0] v);
    logic [`SRA_DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < `SRA_DATA_W; i++) r[i] = v[`SRA_DATA_W-1-i];
    return r;
  endfunction : rev8

  // --------------------------------------------------------------------------
  // pin synchronisers: three stages, a level counts once stages 2 and 3 agree
  // --------------------------------------------------------------------------
  logic [3:0] pinS1;
  logic [3:0] pinS2;
  logic [3:0] pinS3;
  logic [3:0] pinLvl;
  logic sclkPrev;
  wire [3:0] pinAgree;
  wire csLvl;
  wire sclkLvl;
  wire sdiLvl;
  wire phaseLvl;

  assign pinAgree = ~(pinS2 ^ pinS3);
  assign csLvl = pinLvl[3];
  assign sclkLvl = pinLvl[2];
  assign sdiLvl = pinLvl[1];
  assign phaseLvl = pinLvl[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1 <= `SRA_PIN_RESET;
      pinS2 <= `SRA_PIN_RESET;
      pinS3 <= `SRA_PIN_RESET;
      pinLvl <= `SRA_PIN_RESET;
      sclkPrev <= 1'b0;
    end else begin
      pinS1 <= {csN, sclk, sdi, clockPhaseSelectPin};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      pinLvl <= (pinLvl & ~pinAgree) | (pinS3 & pinAgree);
      sclkPrev <= sclkLvl;
    end
  end

  // --------------------------------------------------------------------------
  // edge selection
  // --------------------------------------------------------------------------
  wire selected;
  wire sclkRise;
  wire sclkFall;
  wire sampleEdge;
  wire launchEdge;

  assign selected = !csLvl;
  assign sclkRise = sclkLvl && !sclkPrev;
  assign sclkFall = !sclkLvl && sclkPrev;
  assign sampleEdge = selected && (phaseLvl ? sclkFall : sclkRise);
  assign launchEdge = selected && (phaseLvl ? sclkRise : sclkFall);

  // --------------------------------------------------------------------------
  // transaction state
  // --------------------------------------------------------------------------
  spi_register_access_pkg::phase_e phase;
  logic [`SRA_CTRL_BITS-2:0] ctrlSh;
  logic [3:0] bitCnt;
  logic isRead;
  logic isBurst;
  logic byteDone;
  logic [`SRA_ADDR_W-1:0] addr;
  logic [`SRA_DATA_W-1:0] rxSh;
  logic [`SRA_DATA_W-1:0] txSh;
  logic [`SRA_DATA_W-1:0] nextByte;
  logic rdPending;
  logic pushValid;
  spi_register_access_pkg::wr_word_s pushWord;

  wire [`SRA_CTRL_BITS-1:0] ctrlWord;
  wire [`SRA_ADDR_W-1:0] ctrlAddr;
  wire ctrlLast;
  wire [`SRA_DATA_W-1:0] rxFull;
  wire [`SRA_DATA_W-1:0] rxByte;
  wire rxLast;
  wire [`SRA_DATA_W-1:0] txSrc;
  wire [`SRA_ADDR_W-1:0] addrInc;
  wire fifoInReady;

  assign ctrlWord = {ctrlSh, sdiLvl};
  assign ctrlAddr = bitOrderLsb ? rev14(ctrlWord[14:1]) : ctrlWord[14:1];
  assign ctrlLast = (bitCnt == 4'hf);
  assign rxFull = {rxSh[6:0], sdiLvl};
  assign rxByte = bitOrderLsb ? rev8(rxFull) : rxFull;
  assign rxLast = (bitCnt[2:0] == 3'h7);
  assign txSrc = (bitCnt[2:0] == 3'h0) ? nextByte : txSh;
  assign addrInc = addr + 14'h0001;

  always_ff @(posedge clk) begin
    if (rst || !selected) begin
      phase <= spi_register_access_pkg::PH_IDLE;
      ctrlSh <= '0;
      bitCnt <= '0;
      isRead <= 1'b0;
      isBurst <= 1'b0;
      byteDone <= 1'b0;
      addr <= '0;
      rxSh <= '0;
      txSh <= '0;
      sdoOut <= 1'b0;
      sdoOe <= 1'b0;
      rdReq <= 1'b0;
      pushValid <= 1'b0;
    end else begin
      rdReq <= 1'b0;
      pushValid <= 1'b0;
      unique case (phase)
        spi_register_access_pkg::PH_IDLE: begin
          phase <= spi_register_access_pkg::PH_CTRL;
          bitCnt <= '0;
        end
        spi_register_access_pkg::PH_CTRL: begin
          if (sampleEdge) begin
            ctrlSh <= ctrlWord[14:0];
            bitCnt <= bitCnt + 4'h1;
            if (ctrlLast) begin
              phase <= spi_register_access_pkg::PH_XFER;
              isRead <= ctrlWord[15];
              isBurst <= ctrlWord[0];
              addr <= ctrlAddr;
              rdReq <= ctrlWord[15];
              bitCnt <= '0;
            end
          end
        end
        spi_register_access_pkg::PH_XFER: begin
          if (!isRead && sampleEdge) begin
            rxSh <= rxFull;
            bitCnt <= {1'b0, bitCnt[2:0] + 3'h1};
            if (rxLast) begin
              pushValid <= 1'b1;
              addr <= addrInc;
              if (!isBurst) phase <= spi_register_access_pkg::PH_HALT;
            end
          end
          if (isRead && launchEdge) begin
            sdoOut <= bitOrderLsb ? txSrc[0] : txSrc[7];
            txSh <= bitOrderLsb ? {1'b0, txSrc[7:1]} : {txSrc[6:0], 1'b0};
            sdoOe <= 1'b1;
            bitCnt <= {1'b0, bitCnt[2:0] + 3'h1};
            if (bitCnt[2:0] == 3'h0 && isBurst) begin
              addr <= addrInc;
              rdReq <= 1'b1;
            end
            if (rxLast && !isBurst) byteDone <= 1'b1;
            if (bitCnt[2:0] == 3'h0 && byteDone) begin
              sdoOe <= 1'b0;
              phase <= spi_register_access_pkg::PH_HALT;
            end
          end
        end
        spi_register_access_pkg::PH_HALT: begin
          sdoOe <= 1'b0;
        end
      endcase
    end
  end

  // read request carries the address it was raised for; burst asks for the next one
  always_ff @(posedge clk) begin
    if (rst) begin
      rdAddr <= '0;
      rdPending <= 1'b0;
      nextByte <= '0;
    end else begin
      rdPending <= rdReq;
      if (phase == spi_register_access_pkg::PH_CTRL) rdAddr <= ctrlAddr;
      else if (launchEdge && bitCnt[2:0] == 3'h0 && isBurst) rdAddr <= addrInc;
      if (rdPending) nextByte <= rdData;
    end
  end

  // --------------------------------------------------------------------------
  // write path: captured bytes queue up ahead of the register write port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pushWord <= '0;
      bitOrderLsb <= `SRA_ORDER_RESET;
      wrOverrun <= 1'b0;
      bufReady <= 1'b1;
    end else begin
      bufReady <= fifoInReady;
      if (phase == spi_register_access_pkg::PH_XFER && !isRead && sampleEdge && rxLast) begin
        pushWord <= '{addr: addr, data: rxByte};
        if (addr == `SRA_ORDER_ADDR) begin
          bitOrderLsb <= rxByte[`SRA_ORDER_BIT_HI] | rxByte[`SRA_ORDER_BIT_LO];
        end
      end
      // a byte arriving on a full queue is lost; set wins over the clear
      if (pushValid && !fifoInReady) wrOverrun <= 1'b1;
      else if (phase == spi_register_access_pkg::PH_IDLE && selected) wrOverrun <= 1'b0;
    end
  end

  spi_register_access_pkg::wr_word_s fifoOut;
  wire fifoOutValid;
  wire fifoOutReady;

  assign fifoOutReady = !wrValid || wrReady;

  word_fifo #(
    .WIDTH($bits(spi_register_access_pkg::wr_word_s)),
    .DEPTH(`SRA_FIFO_DEPTH)
  ) writeQueue (
    .clk(clk),
    .rst(rst),
    .inValid(pushValid),
    .inReady(fifoInReady),
    .inData(pushWord),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      wrValid <= 1'b0;
      wrWord <= '0;
    end else if (fifoOutReady) begin
      wrValid <= fifoOutValid;
      if (fifoOutValid) wrWord <= fifoOut;
    end
  end
endmodule : spi_register_access_slave

`default_nettype wire

// ==== inc/spi_register_access_consts.svh ====
// constants of the serial register access port
`ifndef SPI_REGISTER_ACCESS_CONSTS_SVH
`define SPI_REGISTER_ACCESS_CONSTS_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define SRA_ADDR_W 14
`define SRA_DATA_W 8
`define SRA_CTRL_BITS 16

// ----------------------------------------------------------------------------
// bit order control location and fields
// ----------------------------------------------------------------------------
`define SRA_ORDER_ADDR 14'h3fff
`define SRA_ORDER_BIT_LO 3
`define SRA_ORDER_BIT_HI 4
`define SRA_ORDER_RESET 1'b0

// ----------------------------------------------------------------------------
// buffering and pin synchroniser reset levels
// ----------------------------------------------------------------------------
`define SRA_FIFO_DEPTH 4
`define SRA_PIN_RESET 4'h8

`endif

// ==== inc/spi_register_access_pkg.sv ====
// types of the serial register access port
`include "spi_register_access_consts.svh"

package spi_register_access_pkg;

  // one register write: address and byte
  typedef struct packed {
    logic [`SRA_ADDR_W-1:0] addr;
    logic [`SRA_DATA_W-1:0] data;
  } wr_word_s;

  // transaction phase, gray coded along idle -> control -> transfer -> halt
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_CTRL = 2'h1,
    PH_XFER = 2'h3,
    PH_HALT = 2'h2
  } phase_e;

endpackage : spi_register_access_pkg

// ==== tb/spi_register_access_slave_sva.sv ====
// assertions on the serial register access port's pins
`timescale 1ns/100ps
`default_nettype none
module spi_register_access_slave_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // observed pins
  input wire logic csN,
  input wire logic sdoOe,
  input wire logic wrValid,
  input wire spi_register_access_pkg::wr_word_s wrWord,
  input wire logic wrReady,
  input wire logic rdReq,
  input wire logic bitOrderLsb,
  input wire logic wrOverrun,
  input wire logic bufReady
);
  logic [4:0] sinceRd;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // starts saturated so a first read bit needs a request of its own
  always_ff @(posedge clk) begin
    if (rst) sinceRd <= 5'h1f;
    else if (rdReq) sinceRd <= 5'h00;
    else if (sinceRd != 5'h1f) sinceRd <= sinceRd + 5'h01;
  end
  a_oe_deselect: assert property (csN [*6] |-> !sdoOe)
    else $error("serial output driven while deselected");
  a_oe_after_read: assert property ($rose(sdoOe) |-> sinceRd < 5'h09)
    else $error("serial output enabled without a read request");
  a_rd_deselect: assert property (csN [*6] |-> !rdReq)
    else $error("read request while deselected");
  a_rd_pulse: assert property (rdReq |=> !rdReq)
    else $error("read request longer than one cycle");
  a_wr_hold: assert property (wrValid && !wrReady |=> wrValid && $stable(wrWord))
    else $error("pending write word changed");
  a_order_write: assert property (wrValid && wrWord.addr == 14'h3fff |->
    bitOrderLsb == (wrWord.data[4] | wrWord.data[3]))
    else $error("bit order does not follow its control byte");
  a_overrun_full: assert property ($rose(wrOverrun) |-> !bufReady)
    else $error("overrun flagged while queue had room");
  a_reset_state: assert property ($fell(rst) |-> !sdoOe && !wrValid && !rdReq
    && !bitOrderLsb && !wrOverrun && bufReady)
    else $error("outputs not at reset values");
  c_read: cover property (rdReq);
  c_write: cover property (wrValid && wrReady);
  c_overrun: cover property ($rose(wrOverrun));
  c_drive: cover property ($rose(sdoOe));
endmodule : spi_register_access_slave_sva
bind spi_register_access_slave spi_register_access_slave_sva u_sva (
  .clk(clk), .rst(rst), .csN(csN), .sdoOe(sdoOe), .wrValid(wrValid), .wrWord(wrWord),
  .wrReady(wrReady), .rdReq(rdReq), .bitOrderLsb(bitOrderLsb), .wrOverrun(wrOverrun),
  .bufReady(bufReady));
`default_nettype wire

// ==== tb/spi_master_model.sv ====
// serial bus master that drives the slave's pins
`timescale 1ns/100ps
`default_nettype none
module spi_master_model #(
  parameter int HALF = 400
) (
  // serial pins
  output logic csN,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  // mode
  input wire logic ph,
  input wire logic lsb
);
  // ----------------------------------------------------------------------------
  // bit and frame tasks
  // ----------------------------------------------------------------------------
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // read data is taken late in the bit: the slave launches through its pin syncs
  // phase 1 samples at the end of the low half, after the launch on the leading edge settled
  task automatic bitc(input logic b, output logic q);
    if (ph) begin
      sclk = 1'b1;
      sdi = b;
      #HALF sclk = 1'b0;
      #(HALF - 1) q = sdo;
      #1;
    end else begin
      sdi = b;
      #HALF sclk = 1'b1;
      #(HALF - 1) q = sdo;
      #1 sclk = 1'b0;
    end
  endtask : bitc
  task automatic start();
    csN = 1'b0;
    #600;
  endtask : start
  task automatic stop();
    #600 csN = 1'b1;
    #800;
  endtask : stop
  task automatic shift(input logic [15:0] v, input int n, output logic [7:0] q);
    logic b;
    q = 8'h00;
    for (int i = 15; i > 15 - n; i--) begin
      bitc(v[i], b);
      q = {q[6:0], b};
    end
  endtask : shift
  task automatic ctrl(input logic rw, input logic [13:0] a, input logic bu);
    logic [13:0] x;
    logic [7:0] q;
    for (int i = 0; i < 14; i++) x[i] = lsb ? a[13 - i] : a[i];
    shift({rw, x, bu}, 16, q);
  endtask : ctrl
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
    logic [7:0] x;
    for (int i = 0; i < 8; i++) x[i] = lsb ? d[7 - i] : d[i];
    shift({x, 8'h00}, 8, q);
    for (int i = 0; i < 8; i++) x[i] = lsb ? q[7 - i] : q[i];
    q = x;
  endtask : xbyte
  // clock and data wiggle while deselected, ending low
  task automatic noise(input int n);
    repeat (n) begin
      sdi = ~sdi;
      #HALF sclk = ~sclk;
    end
    #HALF;
  endtask : noise
endmodule : spi_master_model
`default_nettype wire

// ==== tb/spi_register_access_slave_bench.sv ====
// self-checking bench of the serial register access port
`include "spi_register_access_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module spi_register_access_slave_bench;
  typedef struct packed {
    logic ph;
    logic rw;
    logic [13:0] addr;
    logic [7:0] data;
    logic [1:0] n;
    logic lsbAfter;
  } row_s;
  row_s rows [8] = '{
    '{1'b0, 1'b0, 14'h0123, 8'ha5, 2'h1, 1'b0}, '{1'b1, 1'b0, 14'h2a5c, 8'h3c, 2'h2, 1'b0},
    '{1'b0, 1'b1, 14'h1555, 8'h00, 2'h1, 1'b0}, '{1'b1, 1'b0, 14'h3fff, 8'h08, 2'h1, 1'b1},
    '{1'b0, 1'b1, 14'h0a81, 8'h00, 2'h1, 1'b1}, '{1'b0, 1'b0, 14'h3fff, 8'h10, 2'h1, 1'b1},
    '{1'b1, 1'b0, 14'h1234, 8'h96, 2'h2, 1'b1}, '{1'b0, 1'b0, 14'h3fff, 8'he7, 2'h1, 1'b0}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wrReady = 1'b1;
  logic ph = 1'b0;
  logic lsb = 1'b0;
  logic sdoHold = 1'b0;
  logic csN, sclk, sdi, sdoOut, sdoOe, wrValid, rdReq, bitOrderLsb, wrOverrun, bufReady;
  logic [13:0] rdAddr;
  logic [7:0] r;
  wire logic [7:0] rdData;
  wire logic sdoLine;
  spi_register_access_pkg::wr_word_s wrWord;
  spi_register_access_pkg::wr_word_s got[$];
  int mismatches = 0;
  int checked = 0;
  int base;
  function automatic logic [7:0] pat(input logic [13:0] a);
    return a[7:0] ^ {2'h0, a[13:8]} ^ 8'h5a;
  endfunction : pat
  // a released line shows the inverse of its last driven value
  assign sdoLine = sdoOe ? sdoOut : ~sdoHold;
  assign rdData = pat(rdAddr);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    if (sdoOe) sdoHold <= sdoOut;
    if (wrValid && wrReady) got.push_back(wrWord);
  end
  spi_register_access_slave u_dut (
    .clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .clockPhaseSelectPin(ph), .wrValid(wrValid), .wrWord(wrWord), .wrReady(wrReady),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdData(rdData), .bitOrderLsb(bitOrderLsb),
    .wrOverrun(wrOverrun), .bufReady(bufReady));
  spi_master_model u_master (
    .csN(csN), .sclk(sclk), .sdi(sdi), .sdo(sdoLine), .ph(ph), .lsb(lsb));
  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic cmpFlag(input logic g, input logic e, input string what);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : cmpFlag
  task automatic cmpData(input logic [21:0] g, input logic [21:0] e, input string what);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %h want %h", $time, what, g, e);
    end
  endtask : cmpData
  task automatic waitCount(input int n);
    for (int t = 0; t < 500 && got.size() < n; t++) @(posedge clk);
    if (got.size() < n) begin
      mismatches++;
      $display("MISMATCH %0t write never arrived", $time);
      summarize();
    end
  endtask : waitCount
  // one frame; burst data counts up from d, single frames may carry ignored extra bytes
  task automatic xfer(input logic rw, input logic [13:0] a, input logic bu, input int n,
      input logic [7:0] d);
    int b;
    int m;
    logic [7:0] q;
    logic [7:0] dk;
    b = got.size();
    m = bu ? n : 1;
    u_master.start();
    u_master.ctrl(rw, a, bu);
    for (int k = 0; k < n; k++) begin
      dk = d + 8'(k);
      u_master.xbyte(dk, q);
      if (rw) cmpData(22'(q), 22'(pat(a + 14'(k))), "read byte");
      if (!rw && a + 14'(k) == `SRA_ORDER_ADDR && k < m) lsb = dk[4] | dk[3];
    end
    u_master.stop();
    if (!rw && wrReady) begin
      for (int k = 0; k < m; k++) begin
        waitCount(b + k + 1);
        cmpData(got[b + k], {a + 14'(k), d + 8'(k)}, "write word");
      end
      tick(8);
      cmpData(22'(got.size() - b), 22'(m), "write count");
    end
  endtask : xfer
  // ----------------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------------
  initial begin
    tick(16);
    rst = 1'b0;
    cmpData(22'({sdoOe, wrValid, rdReq, bitOrderLsb, wrOverrun, bufReady}), 22'h1, "reset");
    tick(2);
    foreach (rows[i]) begin
      ph = rows[i].ph;
      xfer(rows[i].rw, rows[i].addr, 1'b0, rows[i].n, rows[i].data);
      cmpFlag(bitOrderLsb, rows[i].lsbAfter, "bit order");
    end
    ph = 1'b0;
    xfer(1'b0, 14'h3ffe, 1'b1, 3, 8'h17);
    cmpFlag(bitOrderLsb, 1'b1, "order set in burst");
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    lsb = 1'b0;
    cmpFlag(bitOrderLsb, 1'b0, "order after reset");
    xfer(1'b1, 14'h3ffe, 1'b1, 3, 8'h00);
    ph = 1'b1;
    xfer(1'b1, 14'h3fff, 1'b1, 2, 8'h00);
    ph = 1'b0;
    base = got.size();
    u_master.start();
    u_master.ctrl(1'b0, 14'h0777, 1'b0);
    u_master.shift(16'ha500, 7, r);
    u_master.stop();
    u_master.noise(10);
    cmpData(22'(got.size() - base), 22'h0, "aborted byte stored");
    xfer(1'b0, 14'h0778, 1'b0, 1, 8'h5c);
    base = got.size();
    wrReady = 1'b0;
    xfer(1'b0, 14'h0200, 1'b1, 8, 8'h40);
    cmpFlag(wrOverrun, 1'b1, "overrun flag");
    cmpFlag(bufReady, 1'b0, "queue full");
    wrReady = 1'b1;
    waitCount(base + 4);
    for (int k = 0; k < 4; k++) begin
      cmpData(got[base + k], {14'h0200 + 14'(k), 8'h40 + 8'(k)}, "drained word");
    end
    tick(10);
    cmpFlag(bufReady, 1'b1, "queue drained");
    xfer(1'b0, 14'h0300, 1'b0, 1, 8'h81);
    cmpFlag(wrOverrun, 1'b0, "overrun cleared");
    summarize();
  end
endmodule : spi_register_access_slave_bench
`default_nettype wire
